// ===== include/dtbu_pkg.sv
// Package for the debug trigger and breakpoint unit.
// Assumes a single bus clock domain and the CPU core as bus partner.
package dtbu_pkg;
  localparam int DTBU_AW = 16;
  localparam int DTBU_DW = 8;
  localparam int DTBU_FW = 16;
  localparam int DTBU_FD = 8;
  localparam int DTBU_CW = 4;
  localparam logic [3:0] DTBU_CNT_FULL = 4'h8;
  localparam logic [3:0] DTBU_MODE_A_ONLY = 4'h0;
  localparam logic [3:0] DTBU_MODE_A_OR_B = 4'h1;
  localparam logic [3:0] DTBU_MODE_A_THEN_B = 4'h2;
  localparam logic [3:0] DTBU_MODE_EV_B = 4'h3;
  localparam logic [3:0] DTBU_MODE_A_THEN_EV_B = 4'h4;
  localparam logic [3:0] DTBU_MODE_A_AND_D = 4'h5;
  localparam logic [3:0] DTBU_MODE_A_NOT_D = 4'h6;
  localparam logic [3:0] DTBU_MODE_INSIDE = 4'h7;
  localparam logic [3:0] DTBU_MODE_OUTSIDE = 4'h8;
  localparam logic [7:0] DTBU_BYTE_ZERO = 8'h00;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] rdata;
    logic [7:0] wdata;
    logic rw;
    logic valid;
    logic cof;
    logic bdc_access;
    logic opc_fetch;
    logic opc_exec;
  } dtbu_bus_t;

  typedef struct packed {
    logic debug_module_enable;
    logic arm_write;
    logic arm_value;
    logic breakpoint_request_enable;
    logic tag_select;
    logic [3:0] trigger_mode_field;
    logic opcode_tracking_select;
    logic begin_trace;
    logic comparator_a_rw_qualify_enable;
    logic comparator_a_rw_expected;
    logic comparator_b_rw_qualify_enable;
    logic comparator_b_rw_expected;
    logic background_mode_permit;
    logic [15:0] comp_a;
    logic [15:0] comp_b;
  } dtbu_ctrl_t;
endpackage : dtbu_pkg

// ===== rtl/dtbu_unit.sv
// Debug trigger logic with comparators, trace FIFO and breakpoint requests.
// Assumes CPU bus signals are synchronous to ref_clk; control bits are steady levels.
`timescale 1ns/1ps

module dtbu_fifo import dtbu_pkg::*; #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wp_reg;
  logic [PW:0] rp_reg;
  logic [PW:0] diff;
  logic do_wr;
  logic do_rd;
  assign diff = wp_reg - rp_reg;
  assign in_ready = (diff != DEPTH[PW:0]);
  assign out_valid = (diff != '0);
  assign out_data = mem[rp_reg[PW-1:0]];
  assign do_wr = in_valid && (in_ready || do_rd);
  assign do_rd = out_valid && out_ready;
  always_ff @(posedge ref_clk) begin
    if (do_wr) begin
      mem[wp_reg[PW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else if (flush) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      if (do_wr) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (do_rd) begin
        rp_reg <= rp_reg + 1'b1;
      end
    end
  end
endmodule : dtbu_fifo

module dtbu_unit import dtbu_pkg::*; (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire dtbu_bus_t bus,
  input wire dtbu_ctrl_t ctrl,
  input wire logic fifo_low_read,
  output logic [7:0] fifo_port_high_byte,
  output logic [7:0] fifo_port_low_byte,
  output logic run_launched_flag,
  output logic comparator_a_match_flag,
  output logic comparator_b_match_flag,
  output logic [3:0] fifo_word_count,
  output logic tag_request,
  output logic force_request,
  output logic background_entry_opcode,
  output logic software_interrupt_opcode
);
  typedef struct packed {
    logic armed;
    logic a_hit;
    logic b_hit;
    logic a_seen;
    logic started;
    logic [3:0] cnt;
    logic [15:0] port;
    logic tag;
    logic force_q;
    logic bg_entry;
    logic sw_int;
  } dtbu_state_t;

  dtbu_state_t st_reg;
  dtbu_state_t st_next;
  logic en;
  logic a_eq;
  logic b_eq;
  logic a_q;
  logic b_q;
  logic a_trk;
  logic b_trk;
  logic [7:0] dsel;
  logic d_eq;
  logic ev_mode;
  logic begin_eff;
  logic trig;
  logic tag_trig;
  logic store;
  logic [15:0] store_val;
  logic f_in_ready;
  logic f_out_valid;
  logic [15:0] f_out;
  logic f_pop;
  logic f_flush;
  logic f_push;

  assign en = ctrl.debug_module_enable && !bus.bdc_access && bus.valid;
  assign a_eq = en && (bus.addr == ctrl.comp_a);
  assign b_eq = en && (bus.addr == ctrl.comp_b);
  assign a_q = a_eq && (!ctrl.comparator_a_rw_qualify_enable ||
               bus.rw == ctrl.comparator_a_rw_expected);
  assign b_q = b_eq && (!ctrl.comparator_b_rw_qualify_enable ||
               bus.rw == ctrl.comparator_b_rw_expected);
  assign a_trk = ctrl.opcode_tracking_select ? (a_q && bus.opc_exec) : a_q;
  assign b_trk = ctrl.opcode_tracking_select ? (b_q && bus.opc_exec) : b_q;
  assign dsel = (ctrl.comparator_a_rw_qualify_enable && !ctrl.comparator_a_rw_expected)
                ? bus.wdata : bus.rdata;
  assign d_eq = (dsel == ctrl.comp_b[7:0]);
  assign ev_mode = (ctrl.trigger_mode_field == DTBU_MODE_EV_B) ||
                   (ctrl.trigger_mode_field == DTBU_MODE_A_THEN_EV_B);
  assign begin_eff = ev_mode || ctrl.begin_trace;

  always_comb begin
    trig = 1'b0;
    tag_trig = 1'b0;
    case (ctrl.trigger_mode_field)
      DTBU_MODE_A_ONLY: begin
        trig = a_trk;
      end
      DTBU_MODE_A_OR_B: begin
        trig = a_trk || b_trk;
      end
      DTBU_MODE_A_THEN_B: begin
        trig = b_trk && st_reg.a_seen;
      end
      DTBU_MODE_EV_B: begin
        trig = b_trk;
      end
      DTBU_MODE_A_THEN_EV_B: begin
        trig = b_trk && st_reg.a_seen;
      end
      DTBU_MODE_A_AND_D: begin
        trig = a_trk && d_eq;
        tag_trig = a_trk;
      end
      DTBU_MODE_A_NOT_D: begin
        trig = a_trk && !d_eq;
        tag_trig = a_trk;
      end
      DTBU_MODE_INSIDE: begin
        trig = en && (bus.addr >= ctrl.comp_a) && (bus.addr <= ctrl.comp_b);
      end
      DTBU_MODE_OUTSIDE: begin
        trig = en && ((bus.addr < ctrl.comp_a) || (bus.addr > ctrl.comp_b));
      end
      default: begin
        trig = 1'b0;
      end
    endcase
    if (!((ctrl.trigger_mode_field == DTBU_MODE_A_AND_D) ||
          (ctrl.trigger_mode_field == DTBU_MODE_A_NOT_D))) begin
      tag_trig = trig;
    end
  end

  always_comb begin
    store = 1'b0;
    store_val = bus.addr;
    if (st_reg.armed) begin
      if (ev_mode) begin
        store = trig;
        store_val = {DTBU_BYTE_ZERO, bus.rdata};
      end else if (begin_eff) begin
        store = (st_reg.started || trig) && bus.cof;
      end else begin
        store = bus.cof;
      end
    end
  end

  assign f_flush = ctrl.arm_write && ctrl.arm_value;
  assign f_pop = (fifo_low_read && f_out_valid) ||
                 (!st_reg.armed && !begin_eff && store && !f_in_ready) ||
                 (st_reg.armed && !begin_eff && !f_in_ready && store);
  assign f_push = store && (f_in_ready || !begin_eff);

  dtbu_fifo #(.WIDTH(DTBU_FW), .DEPTH(DTBU_FD)) u_fifo (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .flush(f_flush),
    .in_valid(f_push),
    .in_ready(f_in_ready),
    .in_data(store_val),
    .out_valid(f_out_valid),
    .out_ready(f_pop),
    .out_data(f_out)
  );

  always_comb begin
    st_next = st_reg;
    st_next.tag = 1'b0;
    st_next.force_q = 1'b0;
    st_next.bg_entry = 1'b0;
    st_next.sw_int = 1'b0;
    st_next.port = f_out_valid ? f_out : '0;
    if (st_reg.armed) begin
      if (a_trk) begin
        st_next.a_hit = 1'b1;
        st_next.a_seen = 1'b1;
      end
      if (b_trk) begin
        st_next.b_hit = 1'b1;
      end
      if (trig) begin
        st_next.started = 1'b1;
      end
      if (f_push && f_in_ready && st_reg.cnt != DTBU_CNT_FULL) begin
        st_next.cnt = st_reg.cnt + 4'h1;
      end
      if (begin_eff && f_push && st_reg.cnt == DTBU_CNT_FULL - 4'h1) begin
        st_next.armed = 1'b0;
      end
      if (!begin_eff && trig) begin
        st_next.armed = 1'b0;
      end
    end
    if (ctrl.breakpoint_request_enable && st_reg.armed) begin
      if (ctrl.tag_select && tag_trig && bus.opc_fetch) begin
        st_next.tag = 1'b1;
      end else if (!ctrl.tag_select && trig) begin
        st_next.force_q = 1'b1;
      end
      if ((ctrl.tag_select && tag_trig && bus.opc_fetch) || (!ctrl.tag_select && trig)) begin
        st_next.bg_entry = ctrl.background_mode_permit;
        st_next.sw_int = !ctrl.background_mode_permit;
      end
    end
    if (f_flush) begin
      st_next.armed = 1'b1;
      st_next.a_hit = st_reg.armed && a_trk;
      st_next.b_hit = st_reg.armed && b_trk;
      st_next.a_seen = 1'b0;
      st_next.started = 1'b0;
      st_next.cnt = '0;
    end
    if ((ctrl.arm_write && !ctrl.arm_value) || !ctrl.debug_module_enable) begin
      st_next.armed = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign fifo_port_high_byte = st_reg.port[15:8];
  assign fifo_port_low_byte = st_reg.port[7:0];
  assign run_launched_flag = st_reg.armed;
  assign comparator_a_match_flag = st_reg.a_hit;
  assign comparator_b_match_flag = st_reg.b_hit;
  assign fifo_word_count = st_reg.cnt;
  assign tag_request = st_reg.tag;
  assign force_request = st_reg.force_q;
  assign background_entry_opcode = st_reg.bg_entry;
  assign software_interrupt_opcode = st_reg.sw_int;

  property p_arm_start;
    @(posedge ref_clk) disable iff (!reset_n)
    (f_flush && ctrl.debug_module_enable) |=> (run_launched_flag && fifo_word_count == '0);
  endproperty
  a_arm_start: assert property (p_arm_start) else $error("arm did not start run");
  property p_stop;
    @(posedge ref_clk) disable iff (!reset_n)
    !ctrl.debug_module_enable |=> !run_launched_flag;
  endproperty
  a_stop: assert property (p_stop) else $error("run not stopped");
  property p_bdc;
    @(posedge ref_clk) disable iff (!reset_n)
    bus.bdc_access |=> !tag_request && !force_request;
  endproperty
  a_bdc: assert property (p_bdc) else $error("comparator active in bdc access");
  property p_end_trace;
    @(posedge ref_clk) disable iff (!reset_n)
    (st_reg.armed && !begin_eff && trig && !f_flush) |=> !run_launched_flag;
  endproperty
  a_end_trace: assert property (p_end_trace) else $error("end trace did not stop");
  property p_sw_int;
    @(posedge ref_clk) disable iff (!reset_n)
    software_interrupt_opcode |-> !background_entry_opcode && $past(!ctrl.background_mode_permit);
  endproperty
  a_sw_int: assert property (p_sw_int) else $error("software interrupt with permit");
  property p_cnt;
    @(posedge ref_clk) disable iff (!reset_n)
    fifo_word_count <= DTBU_CNT_FULL;
  endproperty
  a_cnt: assert property (p_cnt) else $error("count overflow");
  property p_force;
    @(posedge ref_clk) disable iff (!reset_n)
    force_request |-> $past(!ctrl.tag_select && ctrl.breakpoint_request_enable);
  endproperty
  a_force: assert property (p_force) else $error("force without enable");
  property p_tag;
    @(posedge ref_clk) disable iff (!reset_n)
    tag_request |-> $past(ctrl.tag_select) && !force_request;
  endproperty
  a_tag: assert property (p_tag) else $error("tag wrong");
  property p_a_flag;
    @(posedge ref_clk) disable iff (!reset_n)
    (st_reg.armed && a_trk) |=> comparator_a_match_flag;
  endproperty
  a_a_flag: assert property (p_a_flag) else $error("A match flag not set");
  property p_begin_full;
    @(posedge ref_clk) disable iff (!reset_n)
    (st_reg.armed && begin_eff && f_push && !f_flush &&
     fifo_word_count == DTBU_CNT_FULL - 4'h1) |=> !run_launched_flag;
  endproperty
  a_begin_full: assert property (p_begin_full) else $error("begin trace not ended");
  property p_ev_data;
    @(posedge ref_clk) disable iff (!reset_n)
    (st_reg.armed && ev_mode && f_push) |-> store_val[15:8] == DTBU_BYTE_ZERO;
  endproperty
  a_ev_data: assert property (p_ev_data) else $error("event data high byte set");
  property p_mode_bad;
    @(posedge ref_clk) disable iff (!reset_n)
    (ctrl.trigger_mode_field > DTBU_MODE_OUTSIDE) |-> !trig;
  endproperty
  a_mode_bad: assert property (p_mode_bad) else $error("unused mode triggered");
  property p_track;
    @(posedge ref_clk) disable iff (!reset_n)
    (ctrl.opcode_tracking_select && !bus.opc_exec) |-> !a_trk && !b_trk;
  endproperty
  a_track: assert property (p_track) else $error("untracked match passed");
  property p_stop_arm;
    @(posedge ref_clk) disable iff (!reset_n)
    (ctrl.arm_write && !ctrl.arm_value) |=> !run_launched_flag;
  endproperty
  a_stop_arm: assert property (p_stop_arm) else $error("arm clear did not stop");
  c_trig: cover property (@(posedge ref_clk) disable iff (!reset_n) st_reg.armed && trig);
  c_full: cover property (@(posedge ref_clk) disable iff (!reset_n)
    fifo_word_count == DTBU_CNT_FULL);
  c_brk: cover property (@(posedge ref_clk) disable iff (!reset_n) force_request);
  c_tag: cover property (@(posedge ref_clk) disable iff (!reset_n) tag_request);
  c_end: cover property (@(posedge ref_clk) disable iff (!reset_n)
    st_reg.armed && !begin_eff && trig);
endmodule : dtbu_unit

// ===== bench/dtbu_cpu_model.sv
// CPU side of the bus: one bus cycle per call of cyc, then the bus is let go.
// Assumes the bench calls cyc from its own sequence; ref_clk is the bus clock.
`timescale 1ns/1ps

module dtbu_cpu_model import dtbu_pkg::*; (
  input wire logic ref_clk,
  output dtbu_bus_t bus
);
  initial begin
    bus = '0;
  end

  // Drive after a falling edge, hold across one rising edge, then release
  task automatic cyc(input logic [15:0] a, input logic [7:0] rd, input logic [7:0] wd,
                     input logic rw, input logic [3:0] f);
    @(negedge ref_clk);
    bus.addr = a;
    bus.rdata = rd;
    bus.wdata = wd;
    bus.rw = rw;
    bus.valid = 1'b1;
    {bus.cof, bus.bdc_access, bus.opc_fetch, bus.opc_exec} = f;
    @(negedge ref_clk);
    // Released address, data and rw lines show the inverse of the last value; valid and flags go to 0
    bus.addr = ~a;
    bus.rdata = ~rd;
    bus.wdata = ~wd;
    bus.rw = ~rw;
    bus.valid = 1'b0;
    {bus.cof, bus.bdc_access, bus.opc_fetch, bus.opc_exec} = 4'h0;
  endtask : cyc
endmodule : dtbu_cpu_model

// ===== bench/test_debug_trigger_breakpoint_unit.sv
// Bench for the debug trigger unit: modes, breakpoints, trace FIFO and stop.
// Assumes dtbu_cpu_model drives the bus; mode codes follow the package order.
`timescale 1ns/1ps

module test_debug_trigger_breakpoint_unit;
  import dtbu_pkg::*;
  logic ref_clk, reset_n, fifo_low_read;
  logic [7:0] fh, fl, wd_v;
  logic launched, a_hit, b_hit, tag_q, force_q, bg_q, sw_int_q, rw_v;
  logic [3:0] cnt, s;
  logic [3:0] kind_v;
  dtbu_ctrl_t ctrl;
  dtbu_bus_t bus;
  int failures = 0;
  int checked = 0;

  dtbu_cpu_model cpu (.ref_clk(ref_clk), .bus(bus));
  dtbu_unit dut (.ref_clk(ref_clk), .reset_n(reset_n), .bus(bus), .ctrl(ctrl),
    .fifo_low_read(fifo_low_read), .fifo_port_high_byte(fh), .fifo_port_low_byte(fl),
    .run_launched_flag(launched), .comparator_a_match_flag(a_hit),
    .comparator_b_match_flag(b_hit), .fifo_word_count(cnt), .tag_request(tag_q),
    .force_request(force_q), .background_entry_opcode(bg_q),
    .software_interrupt_opcode(sw_int_q));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  task automatic arm(input logic [3:0] m);
    @(negedge ref_clk);
    ctrl.trigger_mode_field = m;
    ctrl.arm_write = 1'b1;
    ctrl.arm_value = 1'b1;
    @(negedge ref_clk);
    ctrl.arm_write = 1'b0;
    chk({9'h0, launched, a_hit, b_hit, cnt}, 16'h0040, "arm status");
  endtask : arm

  // Check the head word, then pop it with one low-byte read
  task automatic fifo_read(input logic [15:0] exp);
    chk({fh, fl}, exp, "fifo word");
    @(negedge ref_clk);
    fifo_low_read = 1'b1;
    @(negedge ref_clk);
    fifo_low_read = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask : fifo_read

  // One bus cycle, then gather request pulses over four falling edges
  task automatic pulses(input logic [15:0] a, input logic [7:0] rd);
    cpu.cyc(a, rd, wd_v, rw_v, kind_v);
    s = {tag_q, force_q, bg_q, sw_int_q};
    repeat (3) begin
      @(negedge ref_clk);
      s = s | {tag_q, force_q, bg_q, sw_int_q};
    end
  endtask : pulses

  task automatic trig(input logic [3:0] m, input logic [15:0] a, input logic [7:0] rd,
                      input logic e);
    arm(m);
    pulses(a, rd);
    chk({13'h0, s[2:0]}, {13'h0, e, e & ctrl.background_mode_permit,
        e & ~ctrl.background_mode_permit}, "force request and opcode");
  endtask : trig

  task automatic t_modes;
    trig(4'h0, 16'h1200, 8'h80, 1'b1);
    trig(4'h0, 16'h1201, 8'h80, 1'b0);
    kind_v = 4'b0100;
    trig(4'h0, 16'h1200, 8'h80, 1'b0);
    kind_v = 4'b0000;
    trig(4'h1, 16'h1280, 8'h80, 1'b1);
    trig(4'h1, 16'h1240, 8'h80, 1'b0);
    trig(4'h7, 16'h1200, 8'h80, 1'b1);
    trig(4'h7, 16'h1280, 8'h80, 1'b1);
    trig(4'h7, 16'h1281, 8'h80, 1'b0);
    trig(4'h8, 16'h11ff, 8'h80, 1'b1);
    trig(4'h8, 16'h1281, 8'h80, 1'b1);
    trig(4'h8, 16'h1200, 8'h80, 1'b0);
    trig(4'h5, 16'h1200, 8'h80, 1'b1);
    trig(4'h5, 16'h1200, 8'h81, 1'b0);
    trig(4'h6, 16'h1200, 8'h81, 1'b1);
    trig(4'h6, 16'h1200, 8'h80, 1'b0);
    trig(4'hf, 16'h1200, 8'h80, 1'b0);
    ctrl.comparator_a_rw_qualify_enable = 1'b1;
    rw_v = 1'b0;
    trig(4'h5, 16'h1200, 8'h81, 1'b1);
    rw_v = 1'b1;
    trig(4'h0, 16'h1200, 8'h80, 1'b0);
    ctrl.comparator_a_rw_qualify_enable = 1'b0;
    ctrl.background_mode_permit = 1'b0;
    trig(4'h0, 16'h1200, 8'h80, 1'b1);
    ctrl.background_mode_permit = 1'b1;
    ctrl.opcode_tracking_select = 1'b1;
    trig(4'h0, 16'h1200, 8'h80, 1'b0);
    kind_v = 4'b0001;
    trig(4'h0, 16'h1200, 8'h80, 1'b1);
    kind_v = 4'b0000;
    ctrl.opcode_tracking_select = 1'b0;
    $display("mode table done");
  endtask : t_modes

  task automatic t_then_b;
    arm(4'h2);
    pulses(16'h1280, 8'h80);
    chk({15'h0, s[2]}, 16'h0000, "B before A");
    pulses(16'h1200, 8'h80);
    pulses(16'h1280, 8'h80);
    chk({15'h0, s[2]}, 16'h0001, "B after A");
    ctrl.tag_select = 1'b1;
    kind_v = 4'b0010;
    arm(4'h5);
    pulses(16'h1200, 8'h81);
    chk({14'h0, s[3:2]}, 16'h0002, "tag on address alone");
    ctrl.tag_select = 1'b0;
    kind_v = 4'b0000;
    $display("sequence and tag done");
  endtask : t_then_b

  task automatic t_event;
    ctrl.begin_trace = 1'b0;
    arm(4'h3);
    for (int i = 0; i < 9; i++) begin
      pulses(16'h1280, 8'h30 + 8'(i));
    end
    chk({11'h0, launched, cnt}, 16'h0008, "event run full");
    for (int i = 0; i < 8; i++) begin
      chk({fh, fl}, {8'h00, 8'h30 + 8'(i)}, "event data");
      @(negedge ref_clk);
      fifo_low_read = 1'b1;
      @(negedge ref_clk);
      fifo_low_read = 1'b0;
      repeat (2) @(negedge ref_clk);
    end
    ctrl.begin_trace = 1'b1;
    $display("event capture done");
  endtask : t_event

  task automatic t_stop;
    arm(4'h4);
    pulses(16'h1280, 8'h11);
    pulses(16'h1200, 8'h12);
    pulses(16'h1280, 8'h13);
    pulses(16'h1280, 8'h14);
    chk({12'h0, cnt}, 16'h0002, "captures after A");
    @(negedge ref_clk);
    ctrl.arm_write = 1'b1;
    ctrl.arm_value = 1'b0;
    @(negedge ref_clk);
    ctrl.arm_write = 1'b0;
    chk({15'h0, launched}, 16'h0000, "stop by arm");
    arm(4'h0);
    ctrl.debug_module_enable = 1'b0;
    @(negedge ref_clk);
    chk({15'h0, launched}, 16'h0000, "stop by enable");
    ctrl.debug_module_enable = 1'b1;
    $display("stop done");
  endtask : t_stop

  task automatic t_trace;
    kind_v = 4'b1000;
    arm(4'h0);
    pulses(16'h1100, 8'h00);
    pulses(16'h1200, 8'h00);
    for (int i = 0; i < 7; i++) begin
      pulses(16'h1300 + 16'(i), 8'h00);
    end
    chk({11'h0, launched, cnt}, 16'h0008, "begin trace full");
    fifo_read(16'h1200);
    fifo_read(16'h1300);
    ctrl.begin_trace = 1'b0;
    arm(4'h0);
    for (int i = 0; i < 10; i++) begin
      pulses(16'h1300 + 16'(i), 8'h00);
    end
    chk({11'h0, launched, cnt}, 16'h0018, "end trace armed");
    pulses(16'h1200, 8'h00);
    pulses(16'h1400, 8'h00);
    chk({11'h0, launched, cnt}, 16'h0008, "end trace stop");
    fifo_read(16'h1303);
    ctrl.begin_trace = 1'b1;
    kind_v = 4'b0000;
    $display("trace done");
  endtask : t_trace

  initial begin
    ctrl = '0;
    ctrl.debug_module_enable = 1'b1;
    ctrl.breakpoint_request_enable = 1'b1;
    ctrl.begin_trace = 1'b1;
    ctrl.background_mode_permit = 1'b1;
    ctrl.comp_a = 16'h1200;
    ctrl.comp_b = 16'h1280;
    fifo_low_read = 1'b0;
    wd_v = 8'h80;
    rw_v = 1'b1;
    kind_v = 4'h0;
    reset_n = 1'b0;
    repeat (5) @(negedge ref_clk);
    chk({5'h0, launched, a_hit, b_hit, tag_q, force_q, bg_q, sw_int_q, cnt}, 16'h0000, "reset");
    chk({fh, fl}, 16'h0000, "reset port");
    reset_n = 1'b1;
    @(negedge ref_clk);
    $display("reset done");
    t_modes();
    t_then_b();
    t_event();
    t_stop();
    t_trace();
    test_done();
  end
endmodule : test_debug_trigger_breakpoint_unit
